// file: logic/latency_count_readout.sv
/*
 Latency measurement result and status registers, output clock gating
 and lane-align pointer readout for one transceiver.
 Assumes a management front end that presents one register access per
 reg_rd or reg_wr pulse, and comma detect and selection inputs that are
 synchronous to clk.
*/
// Function
// - Low-speed start: start flag per lane
// - High-speed start: bits 0,1 for data halves
// - Low-speed stop: stop flag per lane
// - High-speed stop: bits 0,1 for data halves
// - Done flag set when count valid
// - 20-bit count split over two registers
// - Count saturates at maximum, never wraps
// - Lower register read clears count and flags
// - Channel B clock held when disabled
// - Channel A clock held when disabled
// - Four align locations, lane 3 on top
// - Start select: low-speed tx or high-speed rx
// - Stop select: low-speed rx or high-speed tx
// - Enable bit gates the measurement
// - Channel select routes channel A or B
`timescale 1ns/1ps
module latency_count_readout #(
  parameter int COUNT_W = latency_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic start_point_select,
  input wire logic stop_point_select,
  input wire logic measurement_enable,
  input wire logic measurement_channel_select,
  input wire logic meas_tick,
  input wire logic [3:0] low_speed_transmit_comma_a,
  input wire logic [3:0] low_speed_transmit_comma_b,
  input wire logic [1:0] high_speed_receive_comma_a,
  input wire logic [1:0] high_speed_receive_comma_b,
  input wire logic [3:0] low_speed_receive_comma_a,
  input wire logic [3:0] low_speed_receive_comma_b,
  input wire logic [1:0] high_speed_transmit_comma_a,
  input wire logic [1:0] high_speed_transmit_comma_b,
  input wire logic chan_a_clock_source,
  input wire logic chan_b_clock_source,
  output logic chan_a_clock_output,
  output logic chan_b_clock_output,
  input wire logic [3:0] lane0_align_location,
  input wire logic [3:0] lane1_align_location,
  input wire logic [3:0] lane2_align_location,
  input wire logic [3:0] lane3_align_location
);
  typedef struct packed {
    logic [3:0] start_flags;
    logic [3:0] stop_flags;
    logic [15:0] gating;
    logic [15:0] rdata;
    logic clk_a;
    logic clk_b;
  } readout_state_s;

  readout_state_s s_q;
  readout_state_s s_d;

  logic [3:0] start_src;
  logic [3:0] stop_src;
  logic clear;
  logic [COUNT_W-1:0] count;
  logic [19:0] count_vis;
  logic running;
  logic done;
  logic [15:0] upper_word;

  // Picks the measured channel, then the low- or high-speed point
  function automatic logic [3:0] pick_point(
    input logic chan_b,
    input logic high_speed,
    input logic [3:0] ls_a,
    input logic [3:0] ls_b,
    input logic [1:0] hs_a,
    input logic [1:0] hs_b
  );
    logic [3:0] ls;
    logic [1:0] hs;
    ls = chan_b ? ls_b : ls_a;
    hs = chan_b ? hs_b : hs_a;
    return high_speed ? {2'b00, hs} : ls;
  endfunction

  always_comb begin
    start_src = pick_point(measurement_channel_select, start_point_select,
      low_speed_transmit_comma_a, low_speed_transmit_comma_b,
      high_speed_receive_comma_a, high_speed_receive_comma_b);
    stop_src = pick_point(measurement_channel_select, stop_point_select,
      low_speed_receive_comma_a, low_speed_receive_comma_b,
      high_speed_transmit_comma_a, high_speed_transmit_comma_b);
  end

  // The lower read clears; correct only if the upper word was read first
  assign clear = reg_rd && reg_addr == latency_pkg::ADDR_LOWER_COUNT;

  latency_counter #(
    .COUNT_W(COUNT_W)
  ) u_counter (
    .clk(clk),
    .nrst(nrst),
    .enable(measurement_enable),
    .tick(meas_tick),
    .start(|start_src),
    .stop(|stop_src),
    .clear(clear),
    .count(count),
    .running(running),
    .done(done)
  );

  // Hides the partial count so a read mid-run shows zero
  assign count_vis = done ? 20'(count) : latency_pkg::COUNT_ZERO;

  always_comb begin
    upper_word = '0;
    upper_word[latency_pkg::START_FLAGS_LSB +: 4] = s_q.start_flags;
    upper_word[latency_pkg::STOP_FLAGS_LSB +: 4] = s_q.stop_flags;
    upper_word[latency_pkg::DONE_BIT] = done;
    upper_word[3:0] = count_vis[19:16];
  end

  always_comb begin
    s_d = s_q;
    // Hardware set wins over the clearing read in the same cycle
    if (clear) begin
      s_d.start_flags = '0;
      s_d.stop_flags = '0;
    end
    if (measurement_enable) begin
      s_d.start_flags = s_d.start_flags | start_src;
      s_d.stop_flags = s_d.stop_flags | stop_src;
    end
    if (reg_wr && reg_addr == latency_pkg::ADDR_CLK_GATING) begin
      s_d.gating = reg_wdata & latency_pkg::CLK_GATING_WMASK;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        latency_pkg::ADDR_UPPER_FLAGS: s_d.rdata = upper_word;
        latency_pkg::ADDR_LOWER_COUNT: s_d.rdata = count_vis[15:0];
        latency_pkg::ADDR_CLK_GATING: s_d.rdata = s_q.gating;
        latency_pkg::ADDR_ALIGN_PTRS: begin
          s_d.rdata = {lane3_align_location, lane2_align_location,
            lane1_align_location, lane0_align_location};
        end
        default: s_d.rdata = '0;
      endcase
    end
    // A disabled output parks low instead of stopping mid-level
    s_d.clk_a = s_q.gating[latency_pkg::CHAN_A_EN_BIT] ?
      chan_a_clock_source : 1'b0;
    s_d.clk_b = s_q.gating[latency_pkg::CHAN_B_EN_BIT] ?
      chan_b_clock_source : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{start_flags: 4'h0, stop_flags: 4'h0,
        gating: latency_pkg::CLK_GATING_RESET, rdata: 16'h0000,
        clk_a: 1'b0, clk_b: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign chan_a_clock_output = s_q.clk_a;
  assign chan_b_clock_output = s_q.clk_b;

  property p_clear;
    @(posedge clk) disable iff (!nrst)
    clear && !measurement_enable |=>
      s_q.start_flags == 4'h0 && s_q.stop_flags == 4'h0 && !done;
  endproperty
  a_clear: assert property (p_clear) else
    $error("lower read did not clear flags");

  property p_flag_hold;
    @(posedge clk) disable iff (!nrst)
    s_q.start_flags[0] && !clear |=> s_q.start_flags[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else
    $error("start flag dropped without a clearing read");

  property p_start_ls;
    @(posedge clk) disable iff (!nrst)
    measurement_enable && !start_point_select && !measurement_channel_select
      && low_speed_transmit_comma_a[3] |=> s_q.start_flags[3];
  endproperty
  a_start_ls: assert property (p_start_ls) else
    $error("lane 3 start comma not flagged");

  property p_start_hs;
    @(posedge clk) disable iff (!nrst)
    start_point_select && stop_point_select && measurement_enable
      && s_q.start_flags[3:2] == 2'b00 && s_q.stop_flags[3:2] == 2'b00
      |=> s_q.start_flags[3:2] == 2'b00 && s_q.stop_flags[3:2] == 2'b00;
  endproperty
  a_start_hs: assert property (p_start_hs) else
    $error("unused upper flag bits set in high-speed mode");

  property p_zero_early;
    @(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == latency_pkg::ADDR_LOWER_COUNT && !done
      |=> reg_rdata == 16'h0000;
  endproperty
  a_zero_early: assert property (p_zero_early) else
    $error("count visible before the stop comma");

  property p_upper_read;
    @(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == latency_pkg::ADDR_UPPER_FLAGS
      |=> reg_rdata[3:0] == $past(count_vis[19:16])
        && reg_rdata[4] == $past(done);
  endproperty
  a_upper_read: assert property (p_upper_read) else
    $error("upper word does not match the count");

  property p_gate_a;
    @(posedge clk) disable iff (!nrst)
    !s_q.gating[latency_pkg::CHAN_A_EN_BIT] |=> !chan_a_clock_output;
  endproperty
  a_gate_a: assert property (p_gate_a) else
    $error("channel A clock moved while gated");

  property p_gate_b;
    @(posedge clk) disable iff (!nrst)
    !s_q.gating[latency_pkg::CHAN_B_EN_BIT] |=> !chan_b_clock_output;
  endproperty
  a_gate_b: assert property (p_gate_b) else
    $error("channel B clock moved while gated");

  property p_align;
    @(posedge clk) disable iff (!nrst)
    reg_rd && reg_addr == latency_pkg::ADDR_ALIGN_PTRS
      |=> reg_rdata[15:12] == $past(lane3_align_location)
        && reg_rdata[3:0] == $past(lane0_align_location);
  endproperty
  a_align: assert property (p_align) else
    $error("align pointer readout misplaced");

  // Counter and flags share the start decode, so a run implies a flag
  property p_run_flagged;
    @(posedge clk) disable iff (!nrst)
    running |-> s_q.start_flags != 4'h0;
  endproperty
  a_run_flagged: assert property (p_run_flagged) else
    $error("run active without a latched start comma");
endmodule

// file: logic/latency_pkg.sv
/*
 Constants for the latency count readout: register numbers, field
 positions, reset values and counter limits.
 Assumes nothing; included by package reference only.
*/
package latency_pkg;
  localparam logic [15:0] ADDR_UPPER_FLAGS = 16'h0017;
  localparam logic [15:0] ADDR_LOWER_COUNT = 16'h0018;
  localparam logic [15:0] ADDR_RSVD_CTL_ONE = 16'h0019;
  localparam logic [15:0] ADDR_RSVD_CTL_TWO = 16'h001a;
  localparam logic [15:0] ADDR_RSVD_STAT_ONE = 16'h001b;
  localparam logic [15:0] ADDR_CLK_GATING = 16'h001c;
  localparam logic [15:0] ADDR_ALIGN_PTRS = 16'h001d;

  localparam logic [15:0] CLK_GATING_RESET = 16'h3000;
  // Bits 11:10 of the gating register do not exist and read as zero
  localparam logic [15:0] CLK_GATING_WMASK = 16'hf3ff;
  localparam int CHAN_B_EN_BIT = 13;
  localparam int CHAN_A_EN_BIT = 12;

  localparam int START_FLAGS_LSB = 12;
  localparam int STOP_FLAGS_LSB = 8;
  localparam int DONE_BIT = 4;

  localparam int COUNT_W = 20;
  localparam logic [19:0] COUNT_MAX = 20'hfffff;
  localparam logic [19:0] COUNT_ZERO = 20'h00000;

  typedef enum logic [1:0] {
    MEAS_IDLE = 2'b00,
    MEAS_RUN = 2'b01,
    MEAS_DONE = 2'b11
  } meas_state_e;
endpackage

// file: logic/latency_counter.sv
/*
 Saturating latency cycle counter with a start/stop sequencer.
 Assumes start and stop are already routed from the selected points
 and that tick is a one-cycle enable at the measurement clock rate.
*/
`timescale 1ns/1ps
module latency_counter #(
  parameter int COUNT_W = latency_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic clear,
  output logic [COUNT_W-1:0] count,
  output logic running,
  output logic done
);
  typedef struct packed {
    latency_pkg::meas_state_e st;
    logic [COUNT_W-1:0] cnt;
  } cnt_state_s;

  cnt_state_s s_q;
  cnt_state_s s_d;

  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.st = latency_pkg::MEAS_IDLE;
      s_d.cnt = '0;
    end
    unique case (s_q.st)
      latency_pkg::MEAS_IDLE: begin
        if (enable && start) begin
          s_d.st = latency_pkg::MEAS_RUN;
          s_d.cnt = '0;
        end
      end
      latency_pkg::MEAS_RUN: begin
        if (!enable) begin
          s_d.st = latency_pkg::MEAS_IDLE;
        end else if (stop) begin
          // A stop seen in the clearing cycle still completes the run
          s_d.st = latency_pkg::MEAS_DONE;
          s_d.cnt = s_q.cnt;
        end else if (!clear && tick && s_q.cnt != '1) begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      latency_pkg::MEAS_DONE: begin
      end
      default: begin
        s_d.st = latency_pkg::MEAS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{st: latency_pkg::MEAS_IDLE, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign running = (s_q.st == latency_pkg::MEAS_RUN);
  assign done = (s_q.st == latency_pkg::MEAS_DONE);

  property p_saturate;
    @(posedge clk) disable iff (!nrst)
    running && s_q.cnt == '1 && enable && !stop && !clear
      |=> s_q.cnt == '1;
  endproperty
  a_saturate: assert property (p_saturate) else
    $error("count wrapped past its maximum");

  property p_start;
    @(posedge clk) disable iff (!nrst)
    s_q.st == latency_pkg::MEAS_IDLE && enable && start |=> running;
  endproperty
  a_start: assert property (p_start) else
    $error("start comma did not begin a run");

  property p_stop_done;
    @(posedge clk) disable iff (!nrst)
    running && enable && stop |=> done ##1 (done || $past(clear));
  endproperty
  a_stop_done: assert property (p_stop_done) else
    $error("stop comma did not complete the run");

  property p_disabled;
    @(posedge clk) disable iff (!nrst)
    !enable && !done |=> !running;
  endproperty
  a_disabled: assert property (p_disabled) else
    $error("measurement ran while disabled");
endmodule

// file: verification/mgmt_host.sv
/*
 Management host model: one register read or write per call.
 Assumes a single calling process and the strobes of the readout block.
*/
`timescale 1ns/1ps
module mgmt_host (
  input wire logic clk,
  output logic [15:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_addr = 16'h0000;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
  end

  task access(input logic [15:0] a, input logic w, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = w ? d : ~reg_wdata;
    reg_rd = !w;
    reg_wr = w;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // Released lines show a changed value so nothing stale is reused
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
endmodule

// file: verification/latency_count_readout_tb.sv
/*
 Self-checking bench for the latency count readout.
 Assumes mgmt_host for register access; reads are checked one cycle
 after they are taken.
*/
`timescale 1ns/1ps
module latency_count_readout_tb;
  logic clk, nrst, rd_seen, src_a, src_b, meas_tick;
  logic start_point_select, stop_point_select;
  logic measurement_enable, measurement_channel_select;
  logic [3:0] lst[2], lsr[2];
  logic [1:0] hsr[2], hst[2];
  logic [15:0] lanes, reg_addr, reg_wdata, reg_rdata;
  logic reg_rd, reg_wr, chan_a_clock_output, chan_b_clock_output;
  logic [31:0] seed;
  logic [15:0] exp_q[$];
  logic [15:0] ra[8], re[8];
  int mismatches, num_checks;

  mgmt_host host (.clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);
  latency_count_readout DUT (.clk, .nrst, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .start_point_select, .stop_point_select,
    .measurement_enable, .measurement_channel_select, .meas_tick,
    .low_speed_transmit_comma_a(lst[0]),
    .low_speed_transmit_comma_b(lst[1]),
    .high_speed_receive_comma_a(hsr[0]),
    .high_speed_receive_comma_b(hsr[1]),
    .low_speed_receive_comma_a(lsr[0]),
    .low_speed_receive_comma_b(lsr[1]),
    .high_speed_transmit_comma_a(hst[0]),
    .high_speed_transmit_comma_b(hst[1]),
    .chan_a_clock_source(src_a), .chan_b_clock_source(src_b),
    .chan_a_clock_output, .chan_b_clock_output,
    .lane0_align_location(lanes[3:0]), .lane1_align_location(lanes[7:4]),
    .lane2_align_location(lanes[11:8]),
    .lane3_align_location(lanes[15:12]));

  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task chk(input logic [15:0] got, input logic [15:0] e, input string m);
    num_checks++;
    if (got !== e) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, e);
    end
  endtask

  task close_out;
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("unexpected at %0t: %0d reads unanswered", $time,
        exp_q.size());
    end
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task rd(input logic [15:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    host.access(a, 1'b0, 16'h0000);
  endtask

  // Random commas on the unselected channel must never reach the flags
  task drive(input logic hs, chb, input logic [3:0] st, sp);
    seed = xs(seed);
    for (int c = 0; c < 2; c++) begin
      {lst[c], hsr[c], lsr[c], hst[c]} = (c == chb) ? 12'h000 : seed[11:0];
    end
    if (hs) begin
      hsr[chb] = st[1:0];
      hst[chb] = sp[1:0];
    end else begin
      lst[chb] = st;
      lsr[chb] = sp;
    end
  endtask

  task meas(input logic hs, chb, input logic [3:0] st, sp, input int n);
    logic [3:0] m;
    logic [19:0] c;
    m = hs ? 4'h3 : 4'hf;
    c = 20'(n);
    drive(hs, chb, 4'h0, 4'h0);
    start_point_select = hs;
    stop_point_select = hs;
    measurement_channel_select = chb;
    measurement_enable = 1'b1;
    @(negedge clk);
    drive(hs, chb, st, 4'h0);
    @(negedge clk);
    drive(hs, chb, 4'h0, 4'h0);
    meas_tick = 1'b1;
    repeat (n) @(negedge clk);
    meas_tick = 1'b0;
    rd(16'h0017, {st & m, 12'h000});
    @(negedge clk);
    drive(hs, chb, 4'h0, sp);
    @(negedge clk);
    drive(hs, chb, 4'h0, 4'h0);
    rd(16'h0017, {st & m, sp & m, 4'h1, c[19:16]});
    rd(16'h0018, c[15:0]);
    rd(16'h0017, 16'h0000);
    $display("measurement of %0d ticks done", n);
  endtask

  task gate(input logic [15:0] v);
    host.access(16'h001c, 1'b1, v);
    @(negedge clk);
    repeat (6) begin
      @(negedge clk);
      chk({15'h0, chan_a_clock_output}, {15'h0, v[12] & src_a},
        "clk a");
      chk({15'h0, chan_b_clock_output}, {15'h0, v[13] & src_b},
        "clk b");
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    src_a <= ~src_a;
    if (src_a) begin
      src_b <= ~src_b;
    end
  end

  always @(posedge clk) rd_seen <= reg_rd;

  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      chk(reg_rdata, exp_q.pop_front(), "read");
    end
  end

  initial begin
    #(90000 * 20);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out;
  end

  initial begin
    nrst = 1'b0;
    src_a = 1'b0;
    src_b = 1'b0;
    meas_tick = 1'b0;
    start_point_select = 1'b0;
    stop_point_select = 1'b0;
    measurement_enable = 1'b0;
    measurement_channel_select = 1'b0;
    seed = 32'h18479b75;
    drive(1'b0, 1'b0, 4'h0, 4'h0);
    seed = xs(seed);
    lanes = seed[15:0];
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    ra = '{16'h0017, 16'h0018, 16'h0019, 16'h001a, 16'h001b, 16'h001c,
      16'h001d, 16'h0020};
    re = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      latency_pkg::CLK_GATING_RESET, lanes, 16'h0000};
    foreach (ra[i]) rd(ra[i], re[i]);
    host.access(16'h0019, 1'b1, 16'hffff);
    host.access(16'h0017, 1'b1, 16'hffff);
    rd(16'h0019, 16'h0000);
    rd(16'h0017, 16'h0000);
    host.access(16'h001c, 1'b1, 16'hffff);
    rd(16'h001c, latency_pkg::CLK_GATING_WMASK);
    $display("register test done");
    gate(16'h1000);
    gate(16'h2000);
    gate(16'h3000);
    $display("clock gating test done");
    @(negedge clk);
    drive(1'b0, 1'b0, 4'hf, 4'hf);
    @(negedge clk);
    drive(1'b0, 1'b0, 4'h0, 4'h0);
    rd(16'h0017, 16'h0000);
    $display("disabled test done");
    meas(1'b0, 1'b0, 4'h5, 4'h2, 5);
    meas(1'b1, 1'b1, 4'hf, 4'h2, 3);
    meas(1'b1, 1'b0, 4'h1, 4'h3, 1);
    meas(1'b0, 1'b1, 4'ha, 4'h9, 65539);
    repeat (3) @(negedge clk);
    close_out;
  end
endmodule
